// ==== hdl/uvb_pkg.sv ====
// Constants for the ULPI vendor register bank
package uvb_pkg;
    // Register addresses (6-bit immediate range)
    localparam logic [5:0] UVB_ADDR_TXAMP = 6'h31;
    localparam logic [5:0] UVB_ADDR_AUDIO = 6'h33;
    localparam logic [5:0] UVB_ADDR_IDC_WR = 6'h36;
    localparam logic [5:0] UVB_ADDR_IDC_SET = 6'h37;
    localparam logic [5:0] UVB_ADDR_IDC_CLR = 6'h38;
    localparam logic [5:0] UVB_ADDR_PWR_WR = 6'h39;
    localparam logic [5:0] UVB_ADDR_PWR_SET = 6'h3a;
    localparam logic [5:0] UVB_ADDR_PWR_CLR = 6'h3b;
    localparam logic [5:0] UVB_IMM_MAX = 6'h3f;
    localparam logic [5:0] UVB_EXT_ESCAPE = 6'h2f;
    // Field positions
    localparam int UVB_TXAMP_LSB = 5;
    localparam int UVB_IDC_DONE_BIT = 3;
    localparam int UVB_IDC_GO_BIT = 4;
    localparam int UVB_IDC_RSV_BIT = 5;
    localparam int UVB_IDC_IEN_BIT = 6;
    localparam int UVB_PWR_SWAP_BIT = 1;
    localparam int UVB_PWR_SREG_LSB = 2;
    localparam int UVB_PWR_PUP_BIT = 4;
    localparam int UVB_PWR_PUM_BIT = 5;
    localparam int UVB_PWR_NREG_LSB = 6;
    // Writable masks
    localparam logic [7:0] UVB_TXAMP_MASK = 8'h60;
    localparam logic [7:0] UVB_AUDIO_MASK = 8'h0f;
    localparam logic [7:0] UVB_IDC_WMASK = 8'h70;
    localparam logic [7:0] UVB_PWR_MASK = 8'hfe;
    // Reset values
    localparam logic [1:0] UVB_TXAMP_RST = 2'h0;
    localparam logic [3:0] UVB_AUDIO_RST = 4'h0;
    localparam logic [7:0] UVB_PWR_RST = 8'h04;
    // Audio mode key
    localparam logic [3:0] UVB_AUDIO_KEY = 4'ha;
    // Regulator encoding, shared by both level fields, and the reserved amplitude code
    localparam logic [1:0] UVB_REG_3V3 = 2'h0;
    localparam logic [1:0] UVB_AMP_RSV = 2'h1;
    // Conversion time
    localparam int UVB_CLK_MHZ = 50;
    localparam int UVB_CONV_US = 282;
    localparam int UVB_CONV_CYC = UVB_CONV_US * UVB_CLK_MHZ;
    // Bus operation codes
    typedef enum logic [3:0] {
        UVB_OP_IDLE = 4'b0001,
        UVB_OP_WRITE = 4'b0010,
        UVB_OP_SET = 4'b0100,
        UVB_OP_CLEAR = 4'b1000
    } uvb_op_t;
endpackage : uvb_pkg

// ==== hdl/uvb_conv_timer.sv ====
// Conversion timer: counts a measurement and reports its end
`timescale 1ns/1ns
module uvb_conv_timer
    import uvb_pkg::*;
#(
    parameter int CONV_CYCLES = UVB_CONV_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [15:0] cnt_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            // Start is still high in the cycle done shows; without this the bit would relaunch
            if (start_i && !busy_o && !done_o) begin
                busy_o <= 1'b1;
                cnt_q <= 16'(CONV_CYCLES - 1);
            end else if (busy_o) begin
                if (cnt_q == 16'h0000) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end
endmodule : uvb_conv_timer

// ==== hdl/uvb_bank.sv ====
// ULPI vendor register bank with conversion control and power management
// What this block does
// - Immediate registers answer identically at immediate and extended addresses.
// - Vendor registers sit at 30h-3Fh and use ordinary immediate reads and writes.
// - Two-bit amplitude: 00 nominal default, 10 +7.4 percent, 11 +3.7, 01 reserved.
// - Headset audio mode is on only while the key field equals 1010.
// - Three-bit resistor code reports the converter's measured result.
// - Done flag sets when a conversion ends; a conversion lasts 282 us.
// - Reading the conversion register clears the done flag.
// - Reading the code through the carkit status path leaves done unchanged.
// - Writing or setting the start bit launches a resistance measurement.
// - Start bit clears itself when the conversion completes.
// - With enable set, done raises the alternate interrupt indication.
// - Effective enable is this enable ORed with the carkit enable.
// - Line exchange swaps DP and DM, UART included; speakers untouched.
// - Serial regulator level applies entering UART with transmit enable; default 01.
// - Audio mode forces the regulator to 3.3V.
// - Charger pull-ups on bits 4 and 5, forced on in UART mode.
// - Normal regulator level applies in USB modes; default 00 meaning 3.3V.
// - Power register reads at 39h-3Bh, write 39h, set 3Ah, clear 3Bh.
`timescale 1ns/1ns
module uvb_bank
    import uvb_pkg::*;
#(
    parameter int CONV_CYCLES = UVB_CONV_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_ext_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic carkit_rd_i,
    input wire logic carkit_irq_enable_i,
    input wire logic uart_mode_i,
    input wire logic serial_transmit_enable_i,
    input wire logic [2:0] conv_code_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [1:0] tx_amplitude_o,
    output logic headset_audio_on_o,
    output logic id_measure_busy_o,
    output logic id_alt_int_o,
    output logic [2:0] carkit_code_o,
    output logic carkit_done_o,
    output logic line_exchange_o,
    output logic charger_pullup_plus_o,
    output logic charger_pullup_minus_o,
    output logic [1:0] regulated_supply_level_o
);
    // Fold an extended address onto the immediate map
    function automatic logic [5:0] uvb_map(input logic ext, input logic [7:0] a);
        uvb_map = a[5:0];
        if (ext && a > {2'b00, UVB_IMM_MAX}) begin
            uvb_map = UVB_EXT_ESCAPE;
        end
    endfunction : uvb_map

    // Classify a triple-address register access
    function automatic uvb_op_t uvb_triple(input logic [5:0] a, input logic [5:0] base);
        if (a == base) begin
            uvb_triple = UVB_OP_WRITE;
        end else if (a == base + 6'h01) begin
            uvb_triple = UVB_OP_SET;
        end else if (a == base + 6'h02) begin
            uvb_triple = UVB_OP_CLEAR;
        end else begin
            uvb_triple = UVB_OP_IDLE;
        end
    endfunction : uvb_triple

    function automatic logic [7:0] uvb_apply(input uvb_op_t op, input logic [7:0] cur,
                                             input logic [7:0] d, input logic [7:0] m);
        case (op)
            UVB_OP_WRITE: uvb_apply = d & m;
            UVB_OP_SET: uvb_apply = (cur | d) & m;
            UVB_OP_CLEAR: uvb_apply = cur & ~d & m;
            default: uvb_apply = cur;
        endcase
    endfunction : uvb_apply

    logic [5:0] addr;
    logic [1:0] txamp_q;
    logic [3:0] audio_key_q;
    logic [2:0] code_q;
    logic done_q;
    logic go_q;
    logic rsv5_q;
    logic ien_q;
    logic [7:0] pwr_q;
    logic [7:0] idc_view;
    logic [7:0] rdata_d;
    logic conv_done;
    logic conv_busy;
    logic done_rise;
    logic ien_eff;
    logic audio_on;
    uvb_op_t idc_op;
    uvb_op_t pwr_op;
    logic [7:0] idc_next;
    logic idc_rd;

    assign addr = uvb_map(reg_ext_i, reg_addr_i);
    assign idc_op = reg_wr_i ? uvb_triple(addr, UVB_ADDR_IDC_WR) : UVB_OP_IDLE;
    assign pwr_op = reg_wr_i ? uvb_triple(addr, UVB_ADDR_PWR_WR) : UVB_OP_IDLE;
    assign idc_view = {1'b0, ien_q, rsv5_q, go_q, done_q, code_q};
    assign idc_next = uvb_apply(idc_op, idc_view, reg_wdata_i, UVB_IDC_WMASK | 8'h40);
    assign idc_rd = reg_rd_i && uvb_triple(addr, UVB_ADDR_IDC_WR) != UVB_OP_IDLE;
    assign audio_on = audio_key_q == UVB_AUDIO_KEY;
    assign ien_eff = ien_q | carkit_irq_enable_i;
    assign done_rise = conv_done;

    uvb_conv_timer #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(go_q),
        .busy_o(conv_busy),
        .done_o(conv_done)
    );

    // Simple read/write registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            txamp_q <= UVB_TXAMP_RST;
            audio_key_q <= UVB_AUDIO_RST;
        end else if (ce_i && reg_wr_i) begin
            if (addr == UVB_ADDR_TXAMP) begin
                txamp_q <= reg_wdata_i[UVB_TXAMP_LSB +: 2];
            end
            if (addr == UVB_ADDR_AUDIO) begin
                audio_key_q <= reg_wdata_i[3:0];
            end
        end
    end

    // Conversion register; completion wins over a software write or set of go
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            go_q <= 1'b0;
            rsv5_q <= 1'b0;
            ien_q <= 1'b0;
            code_q <= 3'h0;
            done_q <= 1'b0;
        end else if (ce_i) begin
            if (idc_op != UVB_OP_IDLE) begin
                go_q <= idc_next[UVB_IDC_GO_BIT];
                rsv5_q <= idc_next[UVB_IDC_RSV_BIT];
                ien_q <= idc_next[UVB_IDC_IEN_BIT];
            end
            if (conv_done) begin
                go_q <= 1'b0;
                code_q <= conv_code_i;
                done_q <= 1'b1;
            end else if (idc_rd) begin
                done_q <= 1'b0;
            end
        end
    end

    // Power management register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q <= UVB_PWR_RST;
        end else if (ce_i) begin
            pwr_q <= uvb_apply(pwr_op, pwr_q, reg_wdata_i, UVB_PWR_MASK);
        end
    end

    // Read data; carkit path never touches done
    always_comb begin
        rdata_d = 8'h00;
        case (addr)
            UVB_ADDR_TXAMP: rdata_d = {1'b0, txamp_q, 5'h00};
            UVB_ADDR_AUDIO: rdata_d = {4'h0, audio_key_q};
            UVB_ADDR_IDC_WR, UVB_ADDR_IDC_SET, UVB_ADDR_IDC_CLR: rdata_d = idc_view;
            UVB_ADDR_PWR_WR, UVB_ADDR_PWR_SET, UVB_ADDR_PWR_CLR: rdata_d = pwr_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
            carkit_code_o <= 3'h0;
            carkit_done_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
            carkit_code_o <= code_q;
            carkit_done_o <= done_q;
        end
    end

    // Interrupt indication and analog controls
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            id_alt_int_o <= 1'b0;
            tx_amplitude_o <= UVB_TXAMP_RST;
            headset_audio_on_o <= 1'b0;
            id_measure_busy_o <= 1'b0;
            line_exchange_o <= 1'b0;
            charger_pullup_plus_o <= 1'b0;
            charger_pullup_minus_o <= 1'b0;
            regulated_supply_level_o <= UVB_REG_3V3;
        end else if (ce_i) begin
            id_alt_int_o <= done_rise && ien_eff;
            // Reserved amplitude code falls back to nominal drive
            tx_amplitude_o <= (txamp_q == UVB_AMP_RSV) ? UVB_TXAMP_RST : txamp_q;
            headset_audio_on_o <= audio_on;
            id_measure_busy_o <= conv_busy;
            line_exchange_o <= pwr_q[UVB_PWR_SWAP_BIT];
            charger_pullup_plus_o <= pwr_q[UVB_PWR_PUP_BIT] | uart_mode_i;
            charger_pullup_minus_o <= pwr_q[UVB_PWR_PUM_BIT] | uart_mode_i;
            if (audio_on) begin
                regulated_supply_level_o <= UVB_REG_3V3;
            end else if (uart_mode_i && serial_transmit_enable_i) begin
                regulated_supply_level_o <= pwr_q[UVB_PWR_SREG_LSB +: 2];
            end else if (!uart_mode_i) begin
                regulated_supply_level_o <= pwr_q[UVB_PWR_NREG_LSB +: 2];
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    chk_done_sets: assert property (ce_i && conv_done |=> done_q && !go_q)
        else $error("done flag not set at conversion end");
    chk_done_read_clear: assert property (ce_i && idc_rd && !conv_done |=> !done_q)
        else $error("done flag not cleared by read");
    chk_carkit_keeps: assert property (ce_i && carkit_rd_i && !idc_rd && done_q |=> done_q)
        else $error("carkit read disturbed done flag");
    chk_go_launch: assert property (
        ce_i && !go_q && idc_op == UVB_OP_SET && reg_wdata_i[UVB_IDC_GO_BIT] && !conv_done
        |=> go_q)
        else $error("set of start bit did not launch");
    chk_audio_key: assert property (
        ce_i |=> headset_audio_on_o == $past(audio_key_q == UVB_AUDIO_KEY))
        else $error("audio mode not tied to key");
    chk_alt_int: assert property (ce_i && conv_done && ien_eff |=> id_alt_int_o)
        else $error("alt interrupt missing");
    chk_alt_quiet: assert property (
        ce_i && !(conv_done && ien_eff) |=> !id_alt_int_o)
        else $error("alt interrupt without enabled completion");
    chk_ien_or: assert property (
        ce_i && conv_done && carkit_irq_enable_i && !ien_q |=> id_alt_int_o)
        else $error("carkit enable not ORed in");
    chk_code_capture: assert property (
        ce_i && conv_done |=> code_q == $past(conv_code_i))
        else $error("resistor code not captured at conversion end");
    chk_amp_reserved: assert property (
        ce_i && txamp_q == UVB_AMP_RSV |=> tx_amplitude_o == UVB_TXAMP_RST)
        else $error("reserved amplitude code not nominal");
    chk_amp_follow: assert property (
        ce_i && txamp_q != UVB_AMP_RSV |=> tx_amplitude_o == $past(txamp_q))
        else $error("amplitude output does not follow field");
    chk_pwr_set: assert property (
        ce_i && pwr_op == UVB_OP_SET
        |=> pwr_q == (($past(pwr_q) | $past(reg_wdata_i)) & UVB_PWR_MASK))
        else $error("set access wrong");
    chk_pwr_clear: assert property (
        ce_i && pwr_op == UVB_OP_CLEAR |=> (pwr_q & $past(reg_wdata_i)) == 8'h00)
        else $error("clear access wrong");
    chk_audio_reg: assert property (ce_i && audio_on |=> regulated_supply_level_o == UVB_REG_3V3)
        else $error("regulator not 3.3V in audio mode");
    chk_serial_level: assert property (
        ce_i && !audio_on && uart_mode_i && serial_transmit_enable_i
        |=> regulated_supply_level_o == $past(pwr_q[UVB_PWR_SREG_LSB +: 2]))
        else $error("serial regulator level not applied");
    chk_normal_level: assert property (
        ce_i && !audio_on && !uart_mode_i
        |=> regulated_supply_level_o == $past(pwr_q[UVB_PWR_NREG_LSB +: 2]))
        else $error("normal regulator level not applied");
    chk_swap_follow: assert property (
        ce_i |=> line_exchange_o == $past(pwr_q[UVB_PWR_SWAP_BIT]))
        else $error("line exchange does not follow its bit");
    chk_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    chk_ext_same: assert property (
        ce_i && reg_ext_i && reg_addr_i[7:6] == 2'b00 |-> addr == reg_addr_i[5:0])
        else $error("extended address mismatch");
    chk_uart_pull: assert property (
        ce_i && uart_mode_i |=> charger_pullup_plus_o && charger_pullup_minus_o)
        else $error("pull-ups not forced in UART mode");

    cov_conversion: cover property (go_q ##1 conv_busy);
    cov_read_clear: cover property (done_q && idc_rd);
    cov_swap: cover property (line_exchange_o);
    cov_alt: cover property (id_alt_int_o);
    cov_serial_level: cover property (uart_mode_i && serial_transmit_enable_i && !audio_on);
endmodule : uvb_bank

// ==== bench/uvb_link_model.sv ====
// Link controller model that issues register accesses to the vendor bank
`timescale 1ns/1ns
module uvb_link_model (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic wr_o,
    output logic rd_o,
    output logic ext_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        ext_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // One immediate or extended access; a strobe lasts one cycle
    task automatic access(input logic wr, input logic ext, input logic [7:0] addr,
                          input logic [7:0] data, output logic [7:0] rdata);
        int n;
        // A missing answer leaves unknown data, so a silent read never passes
        rdata = 8'hxx;
        @(negedge mclk_i);
        wr_o = wr;
        rd_o = !wr;
        ext_o = ext;
        addr_o = addr;
        wdata_o = (addr == 8'h36 || addr == 8'h37) ? (data & 8'hdf) : data;
        @(negedge mclk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        // Released lines must not keep looking valid
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        for (n = 0; n < 4 && !wr; n++) begin
            if (rvalid_i === 1'b1) begin
                rdata = rdata_i;
                break;
            end
            @(negedge mclk_i);
        end
    endtask : access
endmodule : uvb_link_model

// ==== bench/tb.sv ====
// Self-checking testbench for the vendor register bank
`timescale 1ns/1ns
module tb;
    import uvb_pkg::*;
    logic mclk, rst, ce, wr, rd, ext, ckrd, ckien, uart, txen, rv, alt;
    logic busy, ckdone, lx, pup, pum, aud;
    logic [7:0] addr, wd, rdata, r;
    logic [2:0] code, ckcode;
    logic [1:0] amp, lvl;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int alt_cnt = 0;

    uvb_bank #(.CONV_CYCLES(20)) dut_u (.mclk_i(mclk), .rst_i(rst), .ce_i(ce),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_ext_i(ext), .reg_addr_i(addr), .reg_wdata_i(wd),
        .carkit_rd_i(ckrd), .carkit_irq_enable_i(ckien), .uart_mode_i(uart),
        .serial_transmit_enable_i(txen), .conv_code_i(code), .reg_rdata_o(rdata),
        .reg_rvalid_o(rv), .tx_amplitude_o(amp), .headset_audio_on_o(aud),
        .id_measure_busy_o(busy), .id_alt_int_o(alt), .carkit_code_o(ckcode),
        .carkit_done_o(ckdone), .line_exchange_o(lx), .charger_pullup_plus_o(pup),
        .charger_pullup_minus_o(pum), .regulated_supply_level_o(lvl));

    uvb_link_model link_u (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rv), .wr_o(wr),
        .rd_o(rd), .ext_o(ext), .addr_o(addr), .wdata_o(wd));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (alt === 1'b1) alt_cnt++;
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask : settle

    task automatic wr8(input logic e, input logic [7:0] a, input logic [7:0] d);
        link_u.access(1'b1, e, a, d, r);
    endtask : wr8

    task automatic rd8(input logic e, input logic [7:0] a, input logic [7:0] exp);
        link_u.access(1'b0, e, a, 8'h00, r);
        chk(r, exp);
    endtask : rd8

    task automatic t_reset;
        rd8(1'b0, 8'h31, 8'h00);
        rd8(1'b0, 8'h33, 8'h00);
        rd8(1'b0, 8'h36, 8'h00);
        rd8(1'b0, 8'h39, 8'h04);
        chk({6'h0, lvl}, 8'h00);
    endtask : t_reset

    task automatic t_amp;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr8(1'b0, 8'h31, {1'b1, c, 5'h1f});
            settle;
            chk({6'h0, amp}, (c == 2'b01) ? 8'h00 : {6'h0, c});
            if (c != 2'b01) rd8(1'b0, 8'h31, {1'b0, c, 5'h00});
        end
        // A write while the clock enable is low must leave the field alone
        @(negedge mclk);
        ce = 1'b0;
        wr8(1'b0, 8'h31, 8'h40);
        ce = 1'b1;
        rd8(1'b0, 8'h31, 8'h60);
    endtask : t_amp

    task automatic t_audio;
        wr8(1'b1, 8'h33, 8'h0a);
        settle;
        chk({7'h0, aud}, 8'h01);
        rd8(1'b0, 8'h33, 8'h0a);
        wr8(1'b0, 8'h33, 8'hfb);
        settle;
        chk({7'h0, aud}, 8'h00);
        rd8(1'b1, 8'h33, 8'h0b);
        rd8(1'b1, 8'h40, 8'h00);
        rd8(1'b0, 8'h32, 8'h00);
        wr8(1'b0, 8'h34, 8'hff);
        rd8(1'b0, 8'h34, 8'h00);
        wr8(1'b0, 8'h33, 8'h00);
    endtask : t_audio

    // Start a measurement, let it finish, then judge flags and reads
    task automatic t_conv(input logic [7:0] a, input logic [7:0] d, input logic ck,
                          input logic [2:0] cd);
        int n;
        int a0;
        wr8(1'b0, 8'h38, 8'h70);
        @(negedge mclk);
        code = cd;
        ckien = ck;
        a0 = alt_cnt;
        wr8(1'b0, a, d);
        settle;
        chk({7'h0, busy}, 8'h01);
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        settle;
        chk(8'(alt_cnt - a0), {7'h0, d[6] | ck});
        @(negedge mclk);
        ckrd = 1'b1;
        @(negedge mclk);
        ckrd = 1'b0;
        settle;
        chk({4'h0, ckdone, ckcode}, {4'h1, cd});
        rd8(1'b0, 8'h38, {1'b0, d[6], 2'b00, 1'b1, cd});
        rd8(1'b0, 8'h36, {1'b0, d[6], 3'b000, cd});
    endtask : t_conv

    task automatic t_pwr;
        wr8(1'b0, 8'h39, 8'hff);
        rd8(1'b0, 8'h39, 8'hfe);
        wr8(1'b0, 8'h3b, 8'h31);
        rd8(1'b0, 8'h3a, 8'hce);
        wr8(1'b0, 8'h3a, 8'h10);
        rd8(1'b0, 8'h3b, 8'hde);
        settle;
        chk({5'h0, lx, pup, pum}, 8'h06);
        chk({6'h0, lvl}, 8'h03);
        wr8(1'b0, 8'h3b, 8'hd0);
        @(negedge mclk);
        uart = 1'b1;
        txen = 1'b1;
        settle;
        chk({4'h0, pup, pum, lvl}, 8'h0f);
        wr8(1'b0, 8'h33, 8'h0a);
        settle;
        chk({6'h0, lvl}, 8'h00);
        wr8(1'b0, 8'h33, 8'h00);
        // Leave UART mode through the reset pin, which also restores the defaults
        @(negedge mclk);
        rst = 1'b1;
        uart = 1'b0;
        txen = 1'b0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        settle;
        chk({6'h0, lvl}, 8'h00);
        chk({5'h0, lx, pup, pum}, 8'h00);
        rd8(1'b0, 8'h39, 8'h04);
    endtask : t_pwr

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ckrd = 1'b0;
        ckien = 1'b0;
        uart = 1'b0;
        txen = 1'b0;
        code = 3'h0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        t_reset;
        t_amp;
        t_audio;
        t_conv(8'h37, 8'h50, 1'b0, 3'b101);
        t_conv(8'h36, 8'h10, 1'b1, 3'b111);
        t_conv(8'h37, 8'h10, 1'b0, 3'b011);
        t_pwr;
        end_of_test;
    end
endmodule : tb
